// file: core/pin_change_pkg.sv
// package: register layout and constants for the port pin-change monitor
package pin_change_pkg;
   // ==========================
   // register map
   localparam logic [7:0] CTRL_ADDR = 8'hB9;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int FLAG_ONE_BIT = 7;
   localparam int GATE_ONE_BIT = 6;
   localparam int SEL_ONE_LSB = 4;
   localparam int FLAG_ZERO_BIT = 3;
   localparam int GATE_ZERO_BIT = 2;
   localparam int SEL_ZERO_LSB = 0;
   // ==========================
   // source codes
   localparam logic [1:0] SEL_A = 2'h0;
   localparam logic [1:0] SEL_B = 2'h1;
   localparam logic [1:0] SEL_C = 2'h2;
   localparam logic [1:0] SEL_D = 2'h3;
   localparam logic [7:0] LOW_NIBBLE_MASK = 8'h0F;
   // ==========================
   // values after reset and when idle
   localparam logic [7:0] SAMPLE_RESET = 8'h00;
   localparam logic [7:0] RDATA_IDLE = 8'h00;

   // special-function register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;
endpackage

// file: core/port_pin_change_monitor.sv
// module: two port pin-change monitors behind one control register
`timescale 1ns/100ps
// ==========================
module port_pin_change_monitor (
   input wire logic clk_i, // system clock
   input wire logic reset_i, // synchronous reset, active high
   input wire pin_change_pkg::sfr_req_t sfr_i, // register bus request
   output logic [7:0] sfr_rdata_o, // register read data
   input wire logic [7:0] port0_i, // port 0 pins
   input wire logic [7:0] port1_i, // port 1 pins
   input wire logic [7:0] port2_i, // port 2 pins
   input wire logic [7:0] port3_i, // port 3 pins
   input wire logic [7:0] port4_i, // port 4 pins
   input wire logic [7:0] port5_i, // port 5 pins
   input wire logic [7:0] port6_i, // port 6 pins
   output logic irq_one_o, // interrupt request, module one
   output logic irq_zero_o // interrupt request, module zero
);
   logic [7:0] change_monitor_control;
   logic [7:0] sample_zero;
   logic [7:0] sample_one;
   logic [1:0] sel_zero_q;
   logic [1:0] sel_one_q;
   logic [7:0] pick_zero;
   logic [7:0] pick_one;
   logic hit_zero;
   logic hit_one;
   logic ctrl_wr;
   logic ctrl_rd;
   logic [1:0] source_select_zero;
   logic [1:0] source_select_one;

   // ==========================
   // shared decode helpers
   // true when a bus request names the control register
   function automatic logic hits_ctrl(input logic [7:0] addr);
      return addr == pin_change_pkg::CTRL_ADDR;
   endfunction

   // a difference only counts when the source was not just switched,
   // otherwise a selector write would compare two unrelated ports
   function automatic logic saw_change(input logic [1:0] sel_prev, input logic [1:0] sel_now,
      input logic [7:0] pins_now, input logic [7:0] pins_prev);
      return (sel_prev == sel_now) && (pins_now != pins_prev);
   endfunction

   // bus strobes that target the control register
   assign ctrl_wr = sfr_i.wr && hits_ctrl(sfr_i.addr);
   assign ctrl_rd = sfr_i.rd && hits_ctrl(sfr_i.addr);
   assign source_select_zero = change_monitor_control[pin_change_pkg::SEL_ZERO_LSB +: 2];
   assign source_select_one = change_monitor_control[pin_change_pkg::SEL_ONE_LSB +: 2];

   // ==========================
   // source multiplexers
   always_comb begin
      case (source_select_zero)
         pin_change_pkg::SEL_A: pick_zero = port0_i;
         pin_change_pkg::SEL_B: pick_zero = port1_i;
         pin_change_pkg::SEL_C: pick_zero = port2_i;
         pin_change_pkg::SEL_D: pick_zero = port3_i;
         default: pick_zero = port0_i;
      endcase
   end

   always_comb begin
      case (source_select_one)
         pin_change_pkg::SEL_A: pick_one = port4_i;
         pin_change_pkg::SEL_B: pick_one = port5_i;
         pin_change_pkg::SEL_C: pick_one = port6_i;
         pin_change_pkg::SEL_D: pick_one = port4_i & pin_change_pkg::LOW_NIBBLE_MASK;
         default: pick_one = port4_i;
      endcase
   end

   // ==========================
   // change detection: compare with last sample, same source only
   assign hit_zero = saw_change(sel_zero_q, source_select_zero, pick_zero, sample_zero);
   assign hit_one = saw_change(sel_one_q, source_select_one, pick_one, sample_one);

   // previous sample and source it came from
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sample_zero <= pin_change_pkg::SAMPLE_RESET;
         sample_one <= pin_change_pkg::SAMPLE_RESET;
         sel_zero_q <= pin_change_pkg::SEL_A;
         sel_one_q <= pin_change_pkg::SEL_A;
      end else begin
         sample_zero <= pick_zero;
         sample_one <= pick_one;
         sel_zero_q <= source_select_zero;
         sel_one_q <= source_select_one;
      end
   end

   // ==========================
   // control register; hardware set wins over software clear
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         change_monitor_control <= pin_change_pkg::CTRL_RESET;
      end else begin
         if (ctrl_wr) begin
            change_monitor_control <= sfr_i.wdata;
         end
         if (hit_one) begin
            change_monitor_control[pin_change_pkg::FLAG_ONE_BIT] <= 1'b1;
         end
         if (hit_zero) begin
            change_monitor_control[pin_change_pkg::FLAG_ZERO_BIT] <= 1'b1;
         end
      end
   end

   // read data from flip-flops
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sfr_rdata_o <= pin_change_pkg::RDATA_IDLE;
      end else begin
         sfr_rdata_o <= ctrl_rd ? change_monitor_control : pin_change_pkg::RDATA_IDLE;
      end
   end

   // interrupt gating
   assign irq_one_o = change_monitor_control[pin_change_pkg::FLAG_ONE_BIT]
      & change_monitor_control[pin_change_pkg::GATE_ONE_BIT];
   assign irq_zero_o = change_monitor_control[pin_change_pkg::FLAG_ZERO_BIT]
      & change_monitor_control[pin_change_pkg::GATE_ZERO_BIT];

   // ==========================
   // assertions
   property p_set_zero;
      @(posedge clk_i) disable iff (reset_i)
         hit_zero |=> change_monitor_control[pin_change_pkg::FLAG_ZERO_BIT];
   endproperty
   a_set_zero: assert property (p_set_zero) else $error("flag zero not set on change");

   property p_set_one;
      @(posedge clk_i) disable iff (reset_i)
         hit_one |=> change_monitor_control[pin_change_pkg::FLAG_ONE_BIT];
   endproperty
   a_set_one: assert property (p_set_one) else $error("flag one not set on change");

   property p_sticky;
      @(posedge clk_i) disable iff (reset_i)
         (change_monitor_control[pin_change_pkg::FLAG_ZERO_BIT] && !ctrl_wr)
            |=> change_monitor_control[pin_change_pkg::FLAG_ZERO_BIT];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag zero cleared by hardware");

   property p_port_zero_hit;
      @(posedge clk_i) disable iff (reset_i)
         (source_select_zero == 2'h1 && $stable(source_select_zero) && port1_i != $past(port1_i)) |-> hit_zero;
   endproperty
   a_port_zero_hit: assert property (p_port_zero_hit) else $error("port one change missed");

   property p_low_nibble;
      @(posedge clk_i) disable iff (reset_i)
         (source_select_one == 2'h3 && $stable(source_select_one)
          && (port4_i[7:4] != $past(port4_i[7:4])) && (port4_i[3:0] == $past(port4_i[3:0]))) |-> !hit_one;
   endproperty
   a_low_nibble: assert property (p_low_nibble) else $error("upper port4 bits flagged");

   property p_irq;
      @(posedge clk_i) disable iff (reset_i)
         irq_zero_o |-> (change_monitor_control[pin_change_pkg::GATE_ZERO_BIT]
            && change_monitor_control[pin_change_pkg::FLAG_ZERO_BIT]);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt without gate");

   property p_ungated;
      @(posedge clk_i) disable iff (reset_i)
         (hit_one && !change_monitor_control[pin_change_pkg::GATE_ONE_BIT])
            |=> change_monitor_control[pin_change_pkg::FLAG_ONE_BIT];
   endproperty
   a_ungated: assert property (p_ungated) else $error("flag blocked by gate");

   property p_sel_quiet;
      @(posedge clk_i) disable iff (reset_i)
         !$stable(source_select_zero) |-> !hit_zero;
   endproperty
   a_sel_quiet: assert property (p_sel_quiet) else $error("selector change raised flag");

   // read data mirrors the control register one cycle after a read
   sequence s_ctrl_read;
      ctrl_rd;
   endsequence

   property p_read_data;
      @(posedge clk_i) disable iff (reset_i)
         s_ctrl_read |=> (sfr_rdata_o == $past(change_monitor_control));
   endproperty
   a_read_data: assert property (p_read_data) else $error("control read data wrong");

   property p_read_other;
      @(posedge clk_i) disable iff (reset_i)
         (sfr_i.rd && !ctrl_rd) |=> (sfr_rdata_o == pin_change_pkg::RDATA_IDLE);
   endproperty
   a_read_other: assert property (p_read_other) else $error("foreign read returned data");

   property p_sticky_one;
      @(posedge clk_i) disable iff (reset_i)
         (change_monitor_control[pin_change_pkg::FLAG_ONE_BIT] && !ctrl_wr)
            |=> change_monitor_control[pin_change_pkg::FLAG_ONE_BIT];
   endproperty
   a_sticky_one: assert property (p_sticky_one) else $error("flag one cleared by hardware");

   // software clear of flag zero, with no change in the same cycle
   sequence s_clear_zero;
      ctrl_wr && !sfr_i.wdata[pin_change_pkg::FLAG_ZERO_BIT] && !hit_zero;
   endsequence

   property p_clear_zero;
      @(posedge clk_i) disable iff (reset_i)
         s_clear_zero |=> !change_monitor_control[pin_change_pkg::FLAG_ZERO_BIT];
   endproperty
   a_clear_zero: assert property (p_clear_zero) else $error("flag zero not cleared by write");

   // a flag may only rise from a pin change or from a write
   property p_rise_zero;
      @(posedge clk_i) disable iff (reset_i)
         ($rose(change_monitor_control[pin_change_pkg::FLAG_ZERO_BIT]) && !$past(ctrl_wr))
            |-> $past(hit_zero);
   endproperty
   a_rise_zero: assert property (p_rise_zero) else $error("flag zero rose without change");

   property p_port_one_hit;
      @(posedge clk_i) disable iff (reset_i)
         (source_select_one == pin_change_pkg::SEL_B && $stable(source_select_one)
          && port5_i != $past(port5_i)) |-> hit_one;
   endproperty
   a_port_one_hit: assert property (p_port_one_hit) else $error("port five change missed");

   property p_irq_one;
      @(posedge clk_i) disable iff (reset_i)
         irq_one_o |-> (change_monitor_control[pin_change_pkg::GATE_ONE_BIT]
            && change_monitor_control[pin_change_pkg::FLAG_ONE_BIT]);
   endproperty
   a_irq_one: assert property (p_irq_one) else $error("interrupt one without gate");

   property p_ungated_zero;
      @(posedge clk_i) disable iff (reset_i)
         (hit_zero && !change_monitor_control[pin_change_pkg::GATE_ZERO_BIT])
            |=> change_monitor_control[pin_change_pkg::FLAG_ZERO_BIT];
   endproperty
   a_ungated_zero: assert property (p_ungated_zero) else $error("flag zero blocked by gate");

   property p_sel_quiet_one;
      @(posedge clk_i) disable iff (reset_i)
         !$stable(source_select_one) |-> !hit_one;
   endproperty
   a_sel_quiet_one: assert property (p_sel_quiet_one) else $error("selector one change raised flag");
endmodule // port_pin_change_monitor

// file: testbench/pin_model.sv
// partner model: external pin levels on the seven ports
`timescale 1ns/100ps
module pin_model (
   input wire logic clk_i, // system clock
   input wire logic reset_i, // synchronous reset, active high
   input wire logic [2:0] idx_i, // port to disturb
   input wire logic [7:0] flip_i, // pins to invert, zero for none
   output logic [55:0] pins_o // all port levels, port 0 lowest
);
   // ==========================
   // pins flip just after an edge, so each change is one clean step
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pins_o <= 56'h0;
      end else begin
         pins_o[idx_i*8 +: 8] <= pins_o[idx_i*8 +: 8] ^ flip_i;
      end
   end
endmodule // pin_model

// file: testbench/port_pin_change_monitor_test.sv
// testbench: control register access and pin change scenarios
`timescale 1ns/100ps
module port_pin_change_monitor_test;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   pin_change_pkg::sfr_req_t req = '0;
   logic [7:0] rdata;
   logic irq_one;
   logic irq_zero;
   logic [2:0] idx = 3'h0;
   logic [7:0] flip = 8'h00;
   logic [55:0] pins;
   int miscompares = 0;
   int checked = 0;
   // ==========================
   // clock, partner and design
   always #5 clk_i = ~clk_i;
   pin_model pin_model_inst (.clk_i(clk_i), .reset_i(reset_i), .idx_i(idx), .flip_i(flip), .pins_o(pins));
   port_pin_change_monitor port_pin_change_monitor_inst (.clk_i(clk_i), .reset_i(reset_i), .sfr_i(req),
      .sfr_rdata_o(rdata), .port0_i(pins[7:0]), .port1_i(pins[15:8]), .port2_i(pins[23:16]),
      .port3_i(pins[31:24]), .port4_i(pins[39:32]), .port5_i(pins[47:40]), .port6_i(pins[55:48]),
      .irq_one_o(irq_one), .irq_zero_o(irq_zero));
   // ==========================
   // shared tasks
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] d);
      @(posedge clk_i) #1 req = '{1'b1, 1'b0, pin_change_pkg::CTRL_ADDR, d};
      @(posedge clk_i) #1 req = '0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i) #1 req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_i) #1 req = '0;
      d = rdata;
   endtask
   task poke(input int p, input logic [7:0] f);
      @(posedge clk_i) #1 idx = p[2:0];
      flip = f;
      @(posedge clk_i) #1 flip = 8'h00;
      repeat (3) @(posedge clk_i);
   endtask
   task end_sim;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ==========================
   // hang guard
   initial begin
      #200000;
      miscompares++;
      end_sim();
   end
   // ==========================
   // main sequence: every selector code of both modules
   initial begin
      logic [7:0] d, ctl, fb, om;
      int p, o;
      repeat (8) @(posedge clk_i);
      #1 reset_i = 1'b0;
      rd(pin_change_pkg::CTRL_ADDR, d);
      check(d, 8'h00);
      rd(8'hB8, d);
      check(d, 8'h00);
      for (int m = 0; m < 2; m++) begin
         for (int c = 0; c < 4; c++) begin
            ctl = (m == 1) ? {2'b01, c[1:0], 4'h0} : {4'h0, 2'b01, c[1:0]};
            fb = (m == 1) ? 8'h80 : 8'h08;
            p = (m == 1) ? ((c == 3) ? 4 : 4 + c) : c;
            o = (m == 1) ? ((c == 3) ? 4 : 4 + (c + 1) % 3) : (c + 1) % 4;
            om = (m == 1 && c == 3) ? 8'hF0 : 8'hFF;
            wr(ctl);
            rd(pin_change_pkg::CTRL_ADDR, d);
            check(d, ctl);
            poke(o, om);
            rd(pin_change_pkg::CTRL_ADDR, d);
            check(d, ctl);
            poke(p, (m == 1 && c == 3) ? 8'h01 : 8'h80);
            rd(pin_change_pkg::CTRL_ADDR, d);
            check(d, ctl | fb);
            check({6'h0, irq_one, irq_zero}, (m == 1) ? 8'h02 : 8'h01);
            repeat (4) @(posedge clk_i);
            rd(pin_change_pkg::CTRL_ADDR, d);
            check(d, ctl | fb);
            wr(ctl);
            check({6'h0, irq_one, irq_zero}, 8'h00);
         end
      end
      // flags set with both gates closed, then gated through
      wr(8'h00);
      poke(0, 8'h01);
      poke(4, 8'h10);
      rd(pin_change_pkg::CTRL_ADDR, d);
      check(d, 8'h88);
      check({6'h0, irq_one, irq_zero}, 8'h00);
      wr(8'hCC);
      check({6'h0, irq_one, irq_zero}, 8'h03);
      wr(8'h00);
      rd(pin_change_pkg::CTRL_ADDR, d);
      check(d, 8'h00);
      end_sim();
   end
endmodule // port_pin_change_monitor_test
